// [src/adc_serial_config_control.sv]
// Serial configuration, result read-out and conversion timing of a delta-sigma converter.
// Assumes all pins are synchronous to clk; the filter supplies conversion_result.
//
// Functional notes
// - Serial input data is sampled on each rising serial clock edge.
// - Shared output low means a new conversion result is ready.
// - Shared output changes only on falling serial clock edges once a frame has begun.
// - Chip select is active low; serial pins are ignored while it is high.
// - External clock select set: timing runs from the external clock input.
// - A different external clock scales rate and notches in proportion.
// - Buffer bit of the first control register enables the input buffer.
// - Polarity bit chooses unipolar or bipolar transfer function.
// - Line bit 0 gives 2.4576 MHz oscillator, 1 gives 2.048 MHz.
// - System ticks, oscillator or external, drive the dividers; timing is divided from them.
// - Rate codes 100 to 111 give 60 to 480 or 50 to 400 sps.
// - Four general pins are driven or read through serial registers.
// - The rate table applies in continuous mode, single-cycle bit clear.
// - Input sampling runs at one tenth of the system clock.
// - Chip select rising releases the shared output.
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"

module adc_serial_config_control #(
  parameter int RESULT_W        = 24,
  parameter int CONT_BASE_TICKS = `CONT_BASE_TICKS
) (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic                cs_b,
  input  wire logic                sclk,
  input  wire logic                din,
  output logic                     rdy_dout,
  output logic                     rdy_dout_oe,
  input  wire logic                ext_clk,
  input  wire logic [3:0]          gpio_in,
  output logic      [3:0]          gpio_out,
  output logic      [3:0]          gpio_oe,
  input  wire logic                conversion_start,
  input  wire logic [RESULT_W-1:0] conversion_result,
  output logic                     conversion_strobe,
  output logic                     sample_strobe,
  output logic                     system_tick,
  output logic                     input_buffer_enable,
  output logic                     unipolar_select,
  output logic                     line_frequency_select,
  output logic                     external_clock_select,
  output logic                     single_cycle_select,
  output logic      [2:0]          rate_code
);

  localparam int OUT_W = 24;
  localparam logic [31:0] INC_A = 32'((`OSC_A_HZ << 32) / `CLK_HZ);
  localparam logic [31:0] INC_B = 32'((`OSC_B_HZ << 32) / `CLK_HZ);

  // Refused at elaboration: results must fit the read-out shift register.
  if (RESULT_W < 8 || RESULT_W > OUT_W || CONT_BASE_TICKS < 16) begin : g_param_check
    $error("adc_serial_config_control parameters out of range");
  end

  logic [7:0]                first_control_register;
  logic [7:0]                gpio_reg;
  logic [RESULT_W-1:0]       result_reg;
  logic                      result_ready;
  logic                      sclk_q;
  logic                      cs_q;
  logic                      ext_q;
  logic [32:0]               osc_acc;
  logic [31:0]               osc_inc;
  logic [5:0]                bit_cnt;
  logic [7:0]                shift_in;
  logic [7:0]                next_byte;
  logic [OUT_W-1:0]          out_sr;
  logic [7:0]                header;
  logic                      conv_busy;
  logic [23:0]               conv_period;
  logic                      sclk_rise;
  logic                      sclk_fall;
  logic                      cs_fall;
  logic                      read_result;
  logic                      write_done;
  adc_ctrl_pkg::xfer_state_t state;
  adc_ctrl_pkg::reg_addr_t   hdr_addr;

  assign sclk_rise = !cs_b && sclk && !sclk_q;
  assign sclk_fall = !cs_b && !sclk && sclk_q;
  assign cs_fall   = !cs_b && cs_q;
  assign next_byte = {shift_in[6:0], din};
  assign hdr_addr  = adc_ctrl_pkg::reg_addr_t'(next_byte[`HDR_ADDR_W-1:0]);

  assign read_result = sclk_rise && state == adc_ctrl_pkg::xfer_header &&
                       bit_cnt == `BYTE_BITS - 6'd1 && next_byte[`HDR_READ_BIT] &&
                       hdr_addr == `ADDR_RESULT;
  assign write_done  = sclk_rise && state == adc_ctrl_pkg::xfer_write &&
                       bit_cnt == `WRITE_BITS - 6'd1;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
      ext_q  <= 1'b0;
    end else begin
      sclk_q <= sclk;
      cs_q   <= cs_b;
      ext_q  <= ext_clk;
    end
  end

  // Line bit picks the oscillator frequency.
  assign osc_inc = line_frequency_select ? INC_B : INC_A;

  // Phase accumulator models the trimmed oscillator.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_acc <= '0;
    end else begin
      osc_acc <= {1'b0, osc_acc[31:0]} + {1'b0, osc_inc};
    end
  end

  // External clock edges replace the oscillator when selected.
  // Every later divider counts these ticks, so rates scale with them.
  assign system_tick = external_clock_select ? (ext_clk && !ext_q) : osc_acc[32];

  // Sampling divides the system clock by ten.
  tick_divider #(.W(16)) sample_div (
    .clk     (clk),
    .rst_b   (rst_b),
    .restart (1'b0),
    .tick    (system_tick),
    .period  (`SAMPLE_DIV),
    .wrap    (sample_strobe)
  );

  // Each step of the rate code halves the period; low codes act as 100.
  always_comb begin
    if (rate_code < `RATE_MIN_CODE) begin
      conv_period = 24'(CONT_BASE_TICKS);
    end else begin
      conv_period = 24'(CONT_BASE_TICKS) >> (rate_code - `RATE_MIN_CODE);
    end
  end

  // Single-cycle mode converts once per start request.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_busy <= 1'b0;
    end else if (!single_cycle_select || conversion_start) begin
      conv_busy <= 1'b1;
    end else if (conversion_strobe) begin
      conv_busy <= 1'b0;
    end
  end

  tick_divider #(.W(24)) conv_div (
    .clk     (clk),
    .rst_b   (rst_b),
    .restart (!conv_busy),
    .tick    (system_tick),
    .period  (conv_period),
    .wrap    (conversion_strobe)
  );

  // A fresh result raises ready; a new result wins over a read clear.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result_ready <= 1'b0;
      result_reg   <= '0;
    end else if (conversion_strobe) begin
      result_ready <= 1'b1;
      result_reg   <= conversion_result;
    end else if (read_result) begin
      result_ready <= 1'b0;
    end
  end

  // Serial data is taken on rising serial clock edges.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state    <= adc_ctrl_pkg::xfer_idle;
      bit_cnt  <= '0;
      shift_in <= '0;
      header   <= '0;
    end else if (cs_b) begin
      state   <= adc_ctrl_pkg::xfer_idle;
      bit_cnt <= '0;
    end else if (sclk_rise) begin
      shift_in <= next_byte;
      bit_cnt  <= bit_cnt + 6'd1;
      case (state)
        adc_ctrl_pkg::xfer_idle: begin
          state <= adc_ctrl_pkg::xfer_header;
        end
        adc_ctrl_pkg::xfer_header: begin
          if (bit_cnt == `BYTE_BITS - 6'd1) begin
            header <= next_byte;
            state  <= next_byte[`HDR_READ_BIT] ? adc_ctrl_pkg::xfer_read
                                                : adc_ctrl_pkg::xfer_write;
          end
        end
        adc_ctrl_pkg::xfer_write: begin
          if (write_done) begin
            state <= adc_ctrl_pkg::xfer_read;
          end
        end
        adc_ctrl_pkg::xfer_read: begin
          state <= adc_ctrl_pkg::xfer_read;
        end
        default: begin
          state <= adc_ctrl_pkg::xfer_idle;
        end
      endcase
    end
  end

  // Frames start counting at idle, so the first rising edge is header bit seven.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      first_control_register <= `CTRL_RESET;
      gpio_reg               <= `GPIO_RESET;
    end else if (write_done && header[`HDR_ADDR_W-1:0] == `ADDR_CTRL) begin
      first_control_register <= next_byte;
    end else if (write_done && header[`HDR_ADDR_W-1:0] == `ADDR_GPIO) begin
      gpio_reg <= next_byte;
    end
  end

  // Buffer bit steers the analog input buffer.
  assign input_buffer_enable   = first_control_register[`CTRL_BUF_BIT];
  // Polarity bit selects the transfer function.
  assign unipolar_select       = first_control_register[`CTRL_UNI_BIT];
  assign line_frequency_select = first_control_register[`CTRL_LINE_BIT];
  assign external_clock_select = first_control_register[`CTRL_EXT_BIT];
  assign single_cycle_select   = first_control_register[`CTRL_SINGLE_BIT];
  assign rate_code             = first_control_register[2:0];

  // Pins follow the register; reads show the live pin levels.
  assign gpio_out = gpio_reg[3:0];
  assign gpio_oe  = gpio_reg[7:4];

  // Read data is loaded at the header edge and shifted out from the next fall.
  // Output updates on falling edges once a frame has begun.
  // Chip select high releases the output.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdy_dout    <= 1'b1;
      rdy_dout_oe <= 1'b0;
      out_sr      <= '0;
    end else if (cs_b) begin
      rdy_dout_oe <= 1'b0;
      rdy_dout    <= 1'b1;
    end else if (cs_fall || state == adc_ctrl_pkg::xfer_idle) begin
      rdy_dout_oe <= 1'b1;
      rdy_dout    <= !result_ready;
    end else if (sclk_rise && state == adc_ctrl_pkg::xfer_header &&
                 bit_cnt == `BYTE_BITS - 6'd1) begin
      case (hdr_addr)
        `ADDR_CTRL:   out_sr <= {first_control_register, 16'h0000};
        `ADDR_GPIO:   out_sr <= {gpio_reg[7:4], gpio_in, 16'h0000};
        `ADDR_RESULT: out_sr <= OUT_W'(result_reg) << (OUT_W - RESULT_W);
        default:      out_sr <= '0;
      endcase
    end else if (sclk_fall && state == adc_ctrl_pkg::xfer_read) begin
      rdy_dout <= out_sr[OUT_W-1];
      out_sr   <= {out_sr[OUT_W-2:0], 1'b0};
    end
  end

  logic [3:0] ticks_since;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ticks_since <= '0;
    end else if (sample_strobe) begin
      ticks_since <= '0;
    end else if (system_tick) begin
      ticks_since <= ticks_since + 4'd1;
    end
  end

  a_output_release: assert property (@(posedge clk) disable iff (!rst_b)
    cs_b |=> !rdy_dout_oe) else $error("shared output driven while deselected");
  a_fall_only_update: assert property (@(posedge clk) disable iff (!rst_b)
    (state == adc_ctrl_pkg::xfer_read && $past(state) == adc_ctrl_pkg::xfer_read &&
     !cs_b && $changed(rdy_dout)) |-> $past(sclk_fall))
    else $error("shared output changed without a falling edge");
  a_ready_low_shown: assert property (@(posedge clk) disable iff (!rst_b)
    (conversion_strobe && !cs_b && state == adc_ctrl_pkg::xfer_idle) |=> ##1 !rdy_dout)
    else $error("new result not shown as ready");
  a_ctrl_write: assert property (@(posedge clk) disable iff (!rst_b)
    (write_done && header[3:0] == 4'h0) |=> first_control_register == $past(next_byte))
    else $error("control write lost");
  a_sample_tenth: assert property (@(posedge clk) disable iff (!rst_b)
    sample_strobe |-> system_tick && ticks_since == 4'd9)
    else $error("sampling not one tenth of system clock");
  a_ext_source: assert property (@(posedge clk) disable iff (!rst_b)
    (external_clock_select && system_tick) |-> (ext_clk && !ext_q))
    else $error("tick not from external clock");
  a_osc_select: assert property (@(posedge clk) disable iff (!rst_b)
    !external_clock_select && $stable(line_frequency_select) |=>
      (osc_acc[31:0] == $past(osc_acc[31:0]) +
                        ($past(line_frequency_select) ? INC_B : INC_A)))
    else $error("oscillator step wrong");
  a_rate_period: assert property (@(posedge clk) disable iff (!rst_b)
    (rate_code == 3'h7) |-> conv_period == 24'(CONT_BASE_TICKS / 8))
    else $error("rate code period wrong");
  a_gpio_drive: assert property (@(posedge clk) disable iff (!rst_b)
    (write_done && header[3:0] == 4'h1) |=> gpio_oe == $past(next_byte[7:4]))
    else $error("pin direction not written");
  a_single_idle: assert property (@(posedge clk) disable iff (!rst_b)
    (single_cycle_select && conversion_strobe && !conversion_start) |=> !conv_busy)
    else $error("single-cycle conversion did not return to idle");

  c_result_read: cover property (@(posedge clk) disable iff (!rst_b) read_result);
  c_ctrl_write: cover property (@(posedge clk) disable iff (!rst_b) write_done);
  c_conversion: cover property (@(posedge clk) disable iff (!rst_b) conversion_strobe);

endmodule

// [shared/adc_ctrl_consts.svh]
// Offsets, field positions, reset values and timing figures of the converter control block.
// Included by the design files; holds definitions only.
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH

// Serial frame: one header byte, then data.
`define HDR_READ_BIT      7
`define HDR_ADDR_W        4
`define BYTE_BITS         6'd8
`define WRITE_BITS        6'd16

// Register addresses.
`define ADDR_CTRL         4'h0
`define ADDR_GPIO         4'h1
`define ADDR_RESULT       4'h2

// First control register fields.
`define CTRL_LINE_BIT     7
`define CTRL_UNI_BIT      6
`define CTRL_EXT_BIT      5
`define CTRL_BUF_BIT      4
`define CTRL_SINGLE_BIT   3
`define CTRL_RESET        8'h04

// General pin register: direction in the high nibble, level in the low.
`define GPIO_RESET        8'h00

// Timing figures.
`define CLK_HZ            64'd250000000
`define OSC_A_HZ          64'd2457600
`define OSC_B_HZ          64'd2048000
`define SAMPLE_DIV        16'd10
`define CONT_BASE_TICKS   40960
`define RATE_MIN_CODE     3'h4

`endif

// [shared/adc_ctrl_pkg.sv]
// Types shared by the converter control design files.
// Assumes nothing beyond a SystemVerilog compiler.
package adc_ctrl_pkg;

  typedef enum logic [1:0] {
    xfer_idle,
    xfer_header,
    xfer_write,
    xfer_read
  } xfer_state_t;

  typedef logic [3:0] reg_addr_t;

endpackage

// [src/tick_divider.sv]
// Counts qualified ticks and pulses once every period ticks.
// Assumes tick is a one-cycle pulse in the clk domain and period is at least one.
`timescale 1ns/1ps

module tick_divider #(
  parameter int W = 24
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         restart,
  input  wire logic         tick,
  input  wire logic [W-1:0] period,
  output logic              wrap
);

  logic [W-1:0] count;

  // Refused at elaboration: a one-bit counter cannot hold a period above one.
  if (W < 2) begin : g_width_check
    $error("tick_divider needs W of at least 2");
  end

  assign wrap = tick && !restart && (count >= period - W'(1));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
    end else if (restart || wrap) begin
      count <= '0;
    end else if (tick) begin
      count <= count + W'(1);
    end
  end

endmodule

// [sim/serial_host.sv]
// Serial host model: frames a header byte and data toward the converter's serial pins.
// Assumes clk is the block clock; every pin moves just after a rising clk edge.
`timescale 1ns/1ps

module serial_host (
  input  wire logic clk,
  input  wire logic rdy_dout,
  input  wire logic rdy_dout_oe,
  output logic      cs_b,
  output logic      sclk,
  output logic      din
);
  initial begin
    cs_b = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end

  // A read takes nrd bits after the header; nrd of zero sends one write data byte.
  // Four clk per serial half period keeps clear of the block's edge detection.
  task automatic frame(input logic [7:0] hdr, input logic [7:0] wd, input int nrd,
                       input bit sel, output logic [23:0] rd, output logic [1:0] first,
                       output int moves);
    int   n;
    logic v;
    n = (nrd == 0) ? 16 : 8 + nrd;
    rd = '0;
    first = '0;
    moves = 0;
    // select held low across the frame when sel is set
    cs_b <= ~sel;
    repeat (4) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      // data set up before the rise
      din <= (i < 8) ? hdr[7-i] : wd[(15-i) & 7];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      if (i == 0) first = {rdy_dout_oe, rdy_dout};
      if (i >= 8) rd = {rd[22:0], rdy_dout};
      v = rdy_dout;
      repeat (4) begin
        @(posedge clk);
        if (i >= 8 && rdy_dout !== v) moves++;
      end
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    cs_b <= 1'b1;
    // After deselect the host inverts din, so its last data level is not left standing.
    din <= ~din;
    repeat (4) @(posedge clk);
  endtask
endmodule

// [sim/tb_adc_serial_config_control.sv]
// Self-checking bench for the converter control block, driven through a serial host model.
// Assumes the hand-over timing: external clock ticks on each rise, base count set to 64.
`timescale 1ns/1ps

module tb_adc_serial_config_control;
  logic        clk = 1'b0;
  logic        rst_b, conversion_start;
  logic        ext_clk = 1'b0;
  logic        cs_b, sclk, din, rdy_dout, rdy_dout_oe;
  logic [3:0]  gpio_in, gpio_out, gpio_oe;
  logic [23:0] conversion_result, rd;
  logic        conversion_strobe, sample_strobe;
  logic        input_buffer_enable, unipolar_select, line_frequency_select;
  logic        external_clock_select, single_cycle_select;
  logic [2:0]  rate_code;
  logic [1:0]  f;
  logic [7:0]  levels;
  int          m, p, e, s0, ext_half, n_fail, checks_done;
  int          ec = 0;
  int          n_strobe = 0;
  localparam logic [7:0] CV [5] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h0b};

  assign levels = {line_frequency_select, unipolar_select, external_clock_select,
                   input_buffer_enable, single_cycle_select, rate_code};

  initial begin
    forever #2 clk = ~clk;
  end

  serial_host host (.clk(clk), .rdy_dout(rdy_dout), .rdy_dout_oe(rdy_dout_oe),
                    .cs_b(cs_b), .sclk(sclk), .din(din));

  adc_serial_config_control #(.RESULT_W(24), .CONT_BASE_TICKS(64)) dut (
    .clk(clk), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk), .din(din),
    .rdy_dout(rdy_dout), .rdy_dout_oe(rdy_dout_oe), .ext_clk(ext_clk),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .conversion_start(conversion_start), .conversion_result(conversion_result),
    .conversion_strobe(conversion_strobe), .sample_strobe(sample_strobe),
    .system_tick(), .input_buffer_enable(input_buffer_enable),
    .unipolar_select(unipolar_select), .line_frequency_select(line_frequency_select),
    .external_clock_select(external_clock_select),
    .single_cycle_select(single_cycle_select), .rate_code(rate_code));

  always @(posedge clk) begin
    if (ec >= ext_half - 1) begin
      ec <= 0;
      ext_clk <= ~ext_clk;
    end else begin
      ec <= ec + 1;
    end
    if (conversion_strobe === 1'b1) n_strobe <= n_strobe + 1;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host.frame({4'h0, a}, d, 0, 1'b1, rd, f, m);
  endtask

  task automatic rdreg(input logic [3:0] a, output logic [7:0] v);
    host.frame({4'h8, a}, 8'h00, 8, 1'b1, rd, f, m);
    v = rd[7:0];
  endtask

  // Waits for one strobe, then counts clk edges up to the next one.
  task automatic meas(input bit smp, output int per);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (((smp ? sample_strobe : conversion_strobe) !== 1'b1) && k < 20000);
    per = 0;
    do begin
      @(posedge clk);
      per++;
    end while (((smp ? sample_strobe : conversion_strobe) !== 1'b1) && per < 20000);
    if (k >= 20000 || per >= 20000) begin
      n_fail++;
      $display("ERROR strobe_wait expected strobe seen none");
      end_of_test();
    end
  endtask

  initial begin
    logic [7:0] v;
    rst_b = 1'b0;
    ext_half = 1;
    gpio_in = 4'h3;
    conversion_start = 1'b0;
    conversion_result = 24'h5a3c96;
    n_fail = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    chk("ctrl_reset", 8'h04, levels);
    chk("out_reset", 2'h1, {rdy_dout_oe, rdy_dout});
    chk("gpio_reset", 8'h00, {gpio_oe, gpio_out});
    foreach (CV[i]) begin
      wr(4'h0, CV[i]);
      chk("ctrl_levels", CV[i], levels);
      rdreg(4'h0, v);
      chk("ctrl_read", CV[i], v);
    end
    wr(4'h1, 8'ha5);
    chk("gpio_drive", 8'ha5, {gpio_oe, gpio_out});
    rdreg(4'h1, v);
    chk("gpio_read", 8'ha3, v);
    wr(4'h5, 8'hff);
    chk("unmapped_write", 8'h0b, levels);
    rdreg(4'h5, v);
    chk("unmapped_read", 8'h00, v);
    host.frame(8'h00, 8'hff, 0, 1'b0, rd, f, m);
    chk("deselected_write", 8'h0b, levels);
    for (int r = 3; r < 8; r++) begin
      wr(4'h0, 8'h20 | r[7:0]);
      meas(1'b0, p);
      e = (r < 4) ? 128 : (128 >> (r - 4));
      chk("conv_period", e, p);
    end
    ext_half = 2;
    meas(1'b0, p);
    chk("conv_slow_ext", 32, p);
    ext_half = 1;
    meas(1'b1, p);
    chk("sample_ext", 20, p);
    wr(4'h0, 8'h04);
    meas(1'b1, p);
    chk("sample_line0", 1, p >= 1012 && p <= 1022);
    wr(4'h0, 8'h84);
    meas(1'b1, p);
    chk("sample_line1", 1, p >= 1215 && p <= 1226);
    wr(4'h0, 8'h24);
    meas(1'b0, p);
    host.frame(8'h82, 8'h00, 24, 1'b1, rd, f, m);
    chk("ready_low", 2'h2, f);
    chk("result", 24'h5a3c96, rd);
    chk("moves_high", 0, m);
    chk("released", 1'b0, rdy_dout_oe);
    wr(4'h0, 8'h2f);
    repeat (100) @(posedge clk);
    s0 = n_strobe;
    repeat (200) @(posedge clk);
    chk("single_idle", 0, n_strobe - s0);
    conversion_start <= 1'b1;
    @(posedge clk);
    conversion_start <= 1'b0;
    repeat (200) @(posedge clk);
    chk("single_one", 1, n_strobe - s0);
    end_of_test();
  end
endmodule
